// File: hdl/sdpll_cfg_pkg.sv
// Package with register map, field layout and synthesis constants
package sdpll_cfg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_OUT_EN = 8'h60;
  localparam logic [7:0] ADDR_DPLL_CTRL = 8'h64;
  localparam logic [7:0] ADDR_PHASE_CTRL = 8'h65;
  localparam logic [7:0] ADDR_STATUS = 8'h67;

  // Reset values
  localparam logic [7:0] RST_OUT_EN = 8'hf6;
  localparam logic [7:0] RST_DPLL_CTRL = 8'h01;
  localparam logic [7:0] RST_PHASE_CTRL = 8'h01;

  // Field positions
  localparam int BITS_EN_BIT = 5;
  localparam int COMP_EN_BIT = 4;
  localparam int SQUELCH_BIT = 6;
  localparam int DUTY_BIT = 5;
  localparam int RATE_BIT = 4;
  localparam int RUN_LSB = 0;
  localparam int PHASE_BIT = 7;

  // Run field codes
  localparam logic [2:0] RUN_OFF = 3'h0;
  localparam logic [2:0] RUN_ON = 3'h1;

  // Composite duty thresholds in eighths of a period
  localparam logic [2:0] DUTY_EVEN = 3'h4;
  localparam logic [2:0] DUTY_5_8 = 3'h5;

  // Synthesis timing
  localparam int ACC_W = 32;
  localparam longint CLK_HZ = 64'h17d7840;
  localparam longint SDH_HZ = 64'h1f4000;
  localparam longint SONET_HZ = 64'h178f40;
  localparam longint COMP_HZ = 64'hfa00;
  localparam logic [ACC_W-1:0] INC_SDH = ACC_W'((SDH_HZ << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_SONET = ACC_W'((SONET_HZ << ACC_W) / CLK_HZ);
  localparam logic [ACC_W-1:0] INC_COMP = ACC_W'((COMP_HZ << ACC_W) / CLK_HZ);

  typedef struct packed {
    logic spare;
    logic auto_output_squelch;
    logic composite_duty_select;
    logic output_rate_standard;
    logic spare3;
    logic [2:0] secondary_dpll_run;
  } dpll_ctrl_t;

  typedef struct packed {
    logic bits_clock;
    logic bits_oe;
    logic composite_clock;
    logic composite_oe;
  } out_pins_t;

endpackage

// File: hdl/phase_accum_clock.sv
// Phase accumulator clock synthesiser with programmable duty threshold
`timescale 1ns/1ps
module phase_accum_clock #(
  parameter int W = 32
) (
  // Clock and control
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic run_in,
  // Frequency word and duty threshold
  input wire logic [W-1:0] inc_in,
  input wire logic [2:0] thresh_in,
  // Synthesised clock
  output logic clk_out
);

  initial begin
    if (W < 8) begin
      $error("phase_accum_clock: W must be at least 8");
    end
  end

  logic [W-1:0] acc_q;
  logic [W-1:0] acc_d;
  logic high_d;

  // Stopped path restarts from phase zero for a clean first edge
  assign acc_d = run_in ? acc_q + inc_in : '0;
  assign high_d = run_in && (acc_d[W-1:W-3] < thresh_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= '0;
      clk_out <= 1'b0;
    end else if (ce_in) begin
      acc_q <= acc_d;
      clk_out <= high_d;
    end
  end

endmodule

// File: hdl/secondary_dpll_output_config.sv
// Secondary DPLL path control, output synthesis, squelch and registers
// Overview of operation
// - With auto squelch set, failed path inputs disable both outputs, else enables rule.
// - The composite clock runs 50:50 duty when duty select is 0 and 5:8 when it is 1.
// - The bits clock runs at 2.048 MHz when rate standard is 0 and 1.544 MHz when 1.
// - Phase measure mode stops the DPLL and flags itself on phase_measure_mode_out.
// - Separate enable bits drive the bits and composite output enables; the two clocks are not gated by them.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module secondary_dpll_output_config #(
  parameter int ACC_W = sdpll_cfg_pkg::ACC_W
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Path status from the input selector
  input wire logic path_inputs_failed_in,
  // Outputs
  output logic bits_clock_output_out,
  output logic bits_output_enable_out,
  output logic composite_clock_output_out,
  output logic composite_output_enable_out,
  output logic dpll_running_out,
  output logic phase_measure_mode_out
);

  initial begin
    if (ACC_W != sdpll_cfg_pkg::ACC_W) begin
      $error("secondary_dpll_output_config: ACC_W must match package increments");
    end
  end

  // Reset release synchroniser
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Failure flag arrives from outside this clock domain
  logic fail_meta_q;
  logic fail_sync_q;
  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      fail_meta_q <= 1'b0;
      fail_sync_q <= 1'b0;
    end else if (ce_in) begin
      fail_meta_q <= path_inputs_failed_in;
      fail_sync_q <= fail_meta_q;
    end
  end

  // Register file
  logic [7:0] out_en_q;
  sdpll_cfg_pkg::dpll_ctrl_t ctrl_q;
  logic [7:0] phase_ctrl_q;
  logic [7:0] rdata_d;
  logic [7:0] status_w;
  logic hit_out_en;
  logic hit_ctrl;
  logic hit_phase;
  logic hit_status;

  assign hit_out_en = addr_in == sdpll_cfg_pkg::ADDR_OUT_EN;
  assign hit_ctrl = addr_in == sdpll_cfg_pkg::ADDR_DPLL_CTRL;
  assign hit_phase = addr_in == sdpll_cfg_pkg::ADDR_PHASE_CTRL;
  assign hit_status = addr_in == sdpll_cfg_pkg::ADDR_STATUS;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      out_en_q <= sdpll_cfg_pkg::RST_OUT_EN;
      ctrl_q <= sdpll_cfg_pkg::RST_DPLL_CTRL;
      phase_ctrl_q <= sdpll_cfg_pkg::RST_PHASE_CTRL;
    end else if (ce_in && wr_in) begin
      if (hit_out_en) begin
        out_en_q <= wdata_in;
      end
      if (hit_ctrl) begin
        ctrl_q <= wdata_in;
      end
      if (hit_phase) begin
        phase_ctrl_q <= wdata_in;
      end
    end
  end

  // Unused control bits read back as written; unmapped reads give zero
  assign status_w = {4'h0, fail_sync_q, phase_measure_mode_out,
                     bits_output_enable_out, dpll_running_out};
  assign rdata_d = hit_out_en ? out_en_q :
                   hit_ctrl ? ctrl_q :
                   hit_phase ? phase_ctrl_q :
                   hit_status ? status_w : 8'h00;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_out <= 8'h00;
    end else if (ce_in) begin
      rdata_out <= rd_in ? rdata_d : 8'h00;
    end
  end

  // Path control decode
  logic phase_mode_w;
  logic run_w;
  logic squelch_w;
  logic bits_oe_d;
  logic comp_oe_d;
  logic [ACC_W-1:0] bits_inc_w;
  logic [2:0] comp_thresh_w;

  assign phase_mode_w = phase_ctrl_q[sdpll_cfg_pkg::PHASE_BIT];
  // Undefined run codes are treated as off rather than guessed at
  assign run_w = (ctrl_q.secondary_dpll_run == sdpll_cfg_pkg::RUN_ON)
                 && !phase_mode_w;
  assign squelch_w = ctrl_q.auto_output_squelch && fail_sync_q;
  assign bits_oe_d = out_en_q[sdpll_cfg_pkg::BITS_EN_BIT] && !squelch_w;
  assign comp_oe_d = out_en_q[sdpll_cfg_pkg::COMP_EN_BIT] && !squelch_w;
  assign bits_inc_w = ctrl_q.output_rate_standard ? sdpll_cfg_pkg::INC_SONET
                                                  : sdpll_cfg_pkg::INC_SDH;
  assign comp_thresh_w = ctrl_q.composite_duty_select ? sdpll_cfg_pkg::DUTY_5_8
                                                      : sdpll_cfg_pkg::DUTY_EVEN;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bits_output_enable_out <= 1'b0;
      composite_output_enable_out <= 1'b0;
      dpll_running_out <= 1'b0;
      phase_measure_mode_out <= 1'b0;
    end else if (ce_in) begin
      bits_output_enable_out <= bits_oe_d;
      composite_output_enable_out <= comp_oe_d;
      dpll_running_out <= run_w;
      phase_measure_mode_out <= phase_mode_w;
    end
  end

  // Output synthesisers; both stop when the DPLL is off
  phase_accum_clock #(
    .W(ACC_W)
  ) u_bits_synth (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_q),
    .ce_in(ce_in),
    .run_in(run_w),
    .inc_in(bits_inc_w),
    .thresh_in(sdpll_cfg_pkg::DUTY_EVEN),
    .clk_out(bits_clock_output_out)
  );

  phase_accum_clock #(
    .W(ACC_W)
  ) u_comp_synth (
    .clk_in(clk_in),
    .rst_n_in(rst_sync_q),
    .ce_in(ce_in),
    .run_in(run_w),
    .inc_in(sdpll_cfg_pkg::INC_COMP),
    .thresh_in(comp_thresh_w),
    .clk_out(composite_clock_output_out)
  );

  // Checker helpers: high-phase length of each clock and how long duty, rate and run
  // have held still. A setting change mid-period legally gives one odd phase, so
  // duty and rate are judged only on phases that fall well after the last change.
  localparam longint EIGHTH = 64'h1 << (ACC_W - 3);
  localparam logic [7:0] COMP_EVEN_MIN =
    8'((EIGHTH * sdpll_cfg_pkg::DUTY_EVEN) / sdpll_cfg_pkg::INC_COMP);
  localparam logic [7:0] COMP_WIDE_MIN =
    8'((EIGHTH * sdpll_cfg_pkg::DUTY_5_8) / sdpll_cfg_pkg::INC_COMP);
  localparam logic [7:0] BITS_SDH_MIN =
    8'((EIGHTH * sdpll_cfg_pkg::DUTY_EVEN) / sdpll_cfg_pkg::INC_SDH);
  localparam logic [7:0] BITS_SONET_MIN =
    8'((EIGHTH * sdpll_cfg_pkg::DUTY_EVEN) / sdpll_cfg_pkg::INC_SONET);
  localparam logic [9:0] SETTLE_MIN = 10'((64'h2 << ACC_W) / sdpll_cfg_pkg::INC_COMP);

  logic [7:0] bits_high_q;
  logic [7:0] bits_high_d;
  logic [7:0] comp_high_q;
  logic [7:0] comp_high_d;
  logic duty_seen_q;
  logic rate_seen_q;
  logic run_seen_q;
  logic cfg_same_w;
  logic [9:0] settle_q;
  logic [9:0] settle_d;
  logic bits_fall_w;
  logic comp_fall_w;
  logic settled_w;

  assign bits_high_d = !bits_clock_output_out ? 8'h00 :
                       (bits_high_q == 8'hff) ? bits_high_q : bits_high_q + 8'h01;
  assign comp_high_d = !composite_clock_output_out ? 8'h00 :
                       (comp_high_q == 8'hff) ? comp_high_q : comp_high_q + 8'h01;
  assign cfg_same_w = (ctrl_q.composite_duty_select == duty_seen_q)
                      && (ctrl_q.output_rate_standard == rate_seen_q)
                      && (run_w == run_seen_q);
  assign settle_d = !cfg_same_w ? 10'h000 :
                    (settle_q == 10'h3ff) ? settle_q : settle_q + 10'h001;
  assign bits_fall_w = !bits_clock_output_out && (bits_high_q != 8'h00);
  assign comp_fall_w = !composite_clock_output_out && (comp_high_q != 8'h00);
  assign settled_w = settle_q >= SETTLE_MIN;

  always_ff @(posedge clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      bits_high_q <= 8'h00;
      comp_high_q <= 8'h00;
      duty_seen_q <= 1'b0;
      rate_seen_q <= 1'b0;
      run_seen_q <= 1'b0;
      settle_q <= 10'h000;
    end else if (ce_in) begin
      bits_high_q <= bits_high_d;
      comp_high_q <= comp_high_d;
      duty_seen_q <= ctrl_q.composite_duty_select;
      rate_seen_q <= ctrl_q.output_rate_standard;
      run_seen_q <= run_w;
      settle_q <= settle_d;
    end
  end

  // Checks
  sequence seq_failed_with_squelch;
    ce_in && ctrl_q.auto_output_squelch && fail_sync_q;
  endsequence

  sequence seq_both_outputs_off;
    !bits_output_enable_out && !composite_output_enable_out;
  endsequence

  property prop_squelch;
    @(posedge clk_in) disable iff (!rst_sync_q)
      seq_failed_with_squelch |=> seq_both_outputs_off;
  endproperty

  AST_SQUELCH: assert property (prop_squelch)
    else $error("outputs not squelched on path failure");

  AST_ENABLE_FOLLOW: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    (ce_in && !ctrl_q.auto_output_squelch) |=>
      (bits_output_enable_out == $past(out_en_q[sdpll_cfg_pkg::BITS_EN_BIT]))
      && (composite_output_enable_out == $past(out_en_q[sdpll_cfg_pkg::COMP_EN_BIT])))
    else $error("output enables do not follow enable bits");

  AST_SQUELCH_IDLE: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    (ce_in && ctrl_q.auto_output_squelch && !fail_sync_q) |=>
      (bits_output_enable_out == $past(out_en_q[sdpll_cfg_pkg::BITS_EN_BIT]))
      && (composite_output_enable_out == $past(out_en_q[sdpll_cfg_pkg::COMP_EN_BIT])))
    else $error("enables dropped with no path failure");

  sequence seq_settled_comp_fall;
    ce_in && settled_w && comp_fall_w;
  endsequence

  sequence seq_settled_bits_fall;
    ce_in && settled_w && bits_fall_w;
  endsequence

  AST_DUTY: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    seq_settled_comp_fall ##0 ctrl_q.composite_duty_select |->
      (comp_high_q == COMP_WIDE_MIN) || (comp_high_q == COMP_WIDE_MIN + 8'h01))
    else $error("composite high phase not 5:8 of its period");

  AST_DUTY_EVEN: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    seq_settled_comp_fall ##0 !ctrl_q.composite_duty_select |->
      (comp_high_q == COMP_EVEN_MIN) || (comp_high_q == COMP_EVEN_MIN + 8'h01))
    else $error("composite high phase not half its period");

  AST_RATE: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    seq_settled_bits_fall ##0 ctrl_q.output_rate_standard |->
      (bits_high_q == BITS_SONET_MIN) || (bits_high_q == BITS_SONET_MIN + 8'h01))
    else $error("bits clock high phase not at the 1.544 MHz rate");

  AST_RATE_SDH: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    seq_settled_bits_fall ##0 !ctrl_q.output_rate_standard |->
      (bits_high_q == BITS_SDH_MIN) || (bits_high_q == BITS_SDH_MIN + 8'h01))
    else $error("bits clock high phase not at the 2.048 MHz rate");

  sequence seq_run_field_off;
    ce_in && (ctrl_q.secondary_dpll_run != sdpll_cfg_pkg::RUN_ON);
  endsequence

  property prop_run_off;
    @(posedge clk_in) disable iff (!rst_sync_q)
      seq_run_field_off ##1 seq_run_field_off |=>
        !dpll_running_out && !bits_clock_output_out && !composite_clock_output_out;
  endproperty

  AST_RUN_OFF: assert property (prop_run_off)
    else $error("DPLL still running with run field off");

  AST_RUN_ON: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    (ce_in && (ctrl_q.secondary_dpll_run == sdpll_cfg_pkg::RUN_ON) && !phase_mode_w)
      |=> dpll_running_out)
    else $error("DPLL not running with run field on");

  AST_PHASE_MODE: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    (ce_in && phase_ctrl_q[7]) |=> (phase_measure_mode_out && !dpll_running_out))
    else $error("phase measure mode did not stop the DPLL");

  AST_PHASE_NORMAL: assert property (@(posedge clk_in) disable iff (!rst_sync_q)
    (ce_in && !phase_mode_w) |=> !phase_measure_mode_out)
    else $error("phase measure mode shown while its bit is clear");

endmodule

// File: verif/tb_top.sv
// Self-checking bench for the secondary DPLL output configuration block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic path_inputs_failed_in = 1'b0;
  logic bits_clock_output_out;
  logic bits_output_enable_out;
  logic composite_clock_output_out;
  logic composite_output_enable_out;
  logic dpll_running_out;
  logic phase_measure_mode_out;
  int fail_count = 0;
  int check_count = 0;
  logic [7:0] rd_v;
  int rises;
  int highs;

  always #20 clk_in = ~clk_in;

  secondary_dpll_output_config dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .path_inputs_failed_in(path_inputs_failed_in),
    .bits_clock_output_out(bits_clock_output_out),
    .bits_output_enable_out(bits_output_enable_out),
    .composite_clock_output_out(composite_clock_output_out),
    .composite_output_enable_out(composite_output_enable_out),
    .dpll_running_out(dpll_running_out), .phase_measure_mode_out(phase_measure_mode_out));

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask

  // Counts bits clock rising edges and composite high cycles
  task automatic measure(input int n);
    logic prev;
    rises = 0;
    highs = 0;
    prev = bits_clock_output_out;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (bits_clock_output_out === 1'b1 && prev === 1'b0) rises++;
      if (composite_clock_output_out === 1'b1) highs++;
      prev = bits_clock_output_out;
    end
  endtask

  task automatic t_reset_map();
    rd_reg(sdpll_cfg_pkg::ADDR_OUT_EN, sdpll_cfg_pkg::RST_OUT_EN);
    rd_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h01);
    rd_reg(sdpll_cfg_pkg::ADDR_PHASE_CTRL, 8'h01);
    rd_reg(sdpll_cfg_pkg::ADDR_STATUS, 8'h03);
    rd_reg(8'h70, 8'h00);
    wr_reg(sdpll_cfg_pkg::ADDR_STATUS, 8'hff);
    rd_reg(sdpll_cfg_pkg::ADDR_STATUS, 8'h03);
    `CHK({dpll_running_out, phase_measure_mode_out}, 2'b10)
  endtask

  task automatic t_enables();
    wr_reg(sdpll_cfg_pkg::ADDR_OUT_EN, 8'h20);
    `CHK({bits_output_enable_out, composite_output_enable_out}, 2'b10)
    wr_reg(sdpll_cfg_pkg::ADDR_OUT_EN, 8'h10);
    `CHK({bits_output_enable_out, composite_output_enable_out}, 2'b01)
    wr_reg(sdpll_cfg_pkg::ADDR_OUT_EN, 8'h30);
  endtask

  task automatic t_squelch();
    @(posedge clk_in);
    path_inputs_failed_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    // Squelch off: failure must not touch the enables
    `CHK({bits_output_enable_out, composite_output_enable_out}, 2'b11)
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h41);
    `CHK({bits_output_enable_out, composite_output_enable_out}, 2'b00)
    rd_reg(sdpll_cfg_pkg::ADDR_STATUS, 8'h09);
    @(posedge clk_in);
    path_inputs_failed_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    #1;
    `CHK({bits_output_enable_out, composite_output_enable_out}, 2'b11)
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h01);
  endtask

  task automatic t_run();
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h00);
    `CHK(dpll_running_out, 1'b0)
    measure(400);
    `CHK(rises, 0)
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h01);
    `CHK(dpll_running_out, 1'b1)
  endtask

  // Clock enable low: a write must be ignored and state must hold
  task automatic t_freeze();
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h00);
    `CHK(dpll_running_out, 1'b1)
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h01);
  endtask

  task automatic t_phase();
    wr_reg(sdpll_cfg_pkg::ADDR_PHASE_CTRL, 8'h81);
    `CHK({dpll_running_out, phase_measure_mode_out}, 2'b01)
    rd_reg(sdpll_cfg_pkg::ADDR_PHASE_CTRL, 8'h81);
    wr_reg(sdpll_cfg_pkg::ADDR_PHASE_CTRL, 8'h01);
    `CHK({dpll_running_out, phase_measure_mode_out}, 2'b10)
  endtask

  // 3125 cycles hold 256 SDH, 193 SONET and 8 composite periods
  task automatic t_rate_duty();
    measure(3125);
    `CHK(rises inside {[255:257]}, 1'b1)
    `CHK(highs inside {[1542:1583]}, 1'b1)
    wr_reg(sdpll_cfg_pkg::ADDR_DPLL_CTRL, 8'h31);
    measure(3125);
    `CHK(rises inside {[192:194]}, 1'b1)
    `CHK(highs inside {[1933:1973]}, 1'b1)
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset_map();
    t_enables();
    t_squelch();
    t_run();
    t_freeze();
    t_phase();
    t_rate_duty();
    report_and_stop();
  end
endmodule
